// ---- logic/smme_entry.sv ----
// smme_entry: management-interrupt acceptance, entry sequence and mode flags
// assumes pipeline drain/write-buffer status from the same clock domain;
// mgmt and nmi request pins are asynchronous and synchronised here
//
// Notes on behaviour
// RULE1 - management interrupt beats nmi and all other external interrupts
// RULE2 - management interrupt inside the mode is latched, taken after exit
// RULE3 - on request stop fetch, let in-flight instructions retire
// RULE4 - wait for write buffer empty before acknowledging
// RULE5 - pulse acknowledge to system logic once draining done
// RULE6 - segment limits are 4 gbyte inside the mode
// RULE7 - 20-bit segment bases, 16-bit default operand and address size
// RULE8 - code segment: selector base>>4, base save base, full limit, rwx
// RULE9 - data segments: selector zero, base zero, full limit, rw
// RULE10 - ip 8000h, flags 0002h, debug 0400h, cr4 and extended_feature_enable zero
// RULE11 - clear pe, em, ts, pg in cr0, keep other bits
// RULE12 - hardware interrupts off on entry, exceptions still allowed
// RULE13 - maskable enable flag cleared on entry, software may set it
// RULE14 - debug control cleared and single-step flag cleared on entry
// RULE15 - nmi in the mode is latched, taken after resume before program
// RULE16 - interrupt return inside mode unmasks nmi until exit
// RULE17 - processor init request ignored inside the mode
// RULE18 - interrupt in the mode pushes only low 16 ip bits
// RULE19 - segment base is selector shifted left by four
// RULE20 - cache lines tagged by mode so no flush on entry or exit
// RULE21 - media, fault-address, priority, debug addr, mtrr, msr not saved
// RULE22 - resume reloads saved state then returns to program
// RULE23 - internal mode flag set at entry end, cleared at resume end
`default_nettype none
module smme_entry
  import smme_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic MGMT_INTERRUPT,
  input wire logic NMI_REQ,
  input wire logic INTR_REQ,
  input wire logic INIT_REQ,
  input wire logic PIPE_EMPTY,
  input wire logic WBUF_EMPTY,
  input wire logic SW_INT,
  input wire logic EXC_REQ,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic HSEL,
  input wire logic HREADY,
  input wire logic [31:0] HWDATA,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  output logic FETCH_STOP,
  output logic MGMT_ACK,
  output logic SYS_MGMT_MODE,
  output logic NMI_TAKE,
  output logic INTR_TAKE,
  output logic INIT_TAKE,
  output logic MGMT_CACHE_TAG,
  output logic ADDR16_DEFAULT,
  output logic [31:0] SEG_LIMIT_OUT,
  output logic [15:0] PUSH_IP,
  output logic [63:0] IP_OUT,
  output logic [63:0] FLAGS_OUT
);
  smme_st_s r;
  smme_st_s next_r;
  logic [3:0] s1;
  logic [3:0] s2;
  logic mgmt_q;
  logic nmi_q;
  logic intr_q;
  logic init_q;
  logic mgmt_rise;
  logic nmi_rise;
  logic wr_ctrl;

  // two-stage synchronisers, first stage feeds only the second
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      s1 <= 4'h0;
      s2 <= 4'h0;
      mgmt_q <= 1'b0;
      nmi_q <= 1'b0;
    end else begin
      s1 <= {INIT_REQ, INTR_REQ, NMI_REQ, MGMT_INTERRUPT};
      s2 <= s1;
      mgmt_q <= s2[0];
      nmi_q <= s2[1];
    end
  end
  assign intr_q = s2[2];
  assign init_q = s2[3];
  // edge-triggered sources so a held pin raises one event
  assign mgmt_rise = s2[0] & ~mgmt_q;
  assign nmi_rise = s2[1] & ~nmi_q;
  assign wr_ctrl = r.rd_act && r.rd_wr && (r.rd_addr == OFS_CTRL[4:2]);

  always_comb begin
    next_r = r;
    next_r.ack = 1'b0;
    next_r.nmi_take = 1'b0;
    // ahb address phase capture; zero wait-state data phase
    next_r.rd_act = HSEL && HREADY && HTRANS[1];
    if (HSEL && HREADY && HTRANS[1]) begin
      next_r.rd_addr = HADDR[4:2];
      next_r.rd_wr = HWRITE;
    end
    if (r.rd_act && !r.rd_wr) begin
      next_r.hrdata = 32'h0000_0000;
    end
    if (HSEL && HREADY && HTRANS[1] && !HWRITE) begin
      case (HADDR[4:2])
        3'd1: next_r.hrdata = {27'h0, r.nmi_unmask, r.nmi_pend, r.mgmt_pend,
                               r.sys_mgmt_mode, r.fetch_stop};
        3'd2: next_r.hrdata = r.save_base;
        3'd3: next_r.hrdata = r.cr0;
        3'd4: next_r.hrdata = r.flags[31:0];
        3'd5: next_r.hrdata = r.ip[31:0];
        3'd6: next_r.hrdata = r.dbg[31:0];
        3'd7: next_r.hrdata = {16'h0000, r.cs.sel};
        default: next_r.hrdata = 32'h0000_0000;
      endcase
    end
    // software writes: flags and debug may be re-enabled by the handler
    if (r.rd_act && r.rd_wr) begin
      case (r.rd_addr)
        3'd2: next_r.save_base = HWDATA;
        3'd3: next_r.cr0 = HWDATA;
        3'd4: next_r.flags[31:0] = HWDATA; // [RULE13]
        3'd5: next_r.ip[31:0] = HWDATA;
        3'd6: next_r.dbg[31:0] = HWDATA;
        default: ;
      endcase
    end
    // pending latches: set wins over clear
    if (mgmt_rise) begin
      next_r.mgmt_pend = 1'b1; // [RULE2]
    end
    if (nmi_rise && r.sys_mgmt_mode && !r.nmi_unmask) begin
      next_r.nmi_pend = 1'b1; // [RULE15]
    end
    case (r.state)
      ST_RUN: begin
        // management request checked before nmi [RULE1]
        if (r.mgmt_pend) begin
          next_r.mgmt_pend = mgmt_rise;
          next_r.fetch_stop = 1'b1; // [RULE3]
          next_r.state = ST_DRAIN;
        end else if (r.nmi_pend) begin
          next_r.nmi_pend = 1'b0;
          next_r.nmi_take = 1'b1; // [RULE15]
        end
      end
      ST_DRAIN: begin
        if (PIPE_EMPTY && WBUF_EMPTY) begin // [RULE3] [RULE4]
          next_r.state = ST_ACK;
        end
      end
      ST_ACK: begin
        next_r.ack = 1'b1; // [RULE5]
        // save area kept internally; unsaved cr4 and extended_feature_enable are zeroed at load, not restored [RULE21]
        next_r.sv_cr0 = r.cr0;
        next_r.sv_flags = r.flags;
        next_r.sv_ip = r.ip;
        next_r.sv_dbg = r.dbg;
        next_r.state = ST_LOAD;
      end
      ST_LOAD: begin
        next_r.cs.sel = r.save_base[SEL_SHIFT +: 16]; // [RULE8]
        next_r.cs.base = r.save_base;
        next_r.cs.limit = SEG_LIMIT; // [RULE6]
        next_r.cs.attr = ATTR_RWX;
        next_r.ds.sel = DATA_SEL; // [RULE9]
        next_r.ds.base = seg_base(DATA_SEL); // [RULE19]
        next_r.ds.limit = SEG_LIMIT;
        next_r.ds.attr = ATTR_RW;
        next_r.ip = ENTRY_IP; // [RULE10]
        next_r.flags = ENTRY_FLAGS; // [RULE13] [RULE14]
        next_r.dbg = ENTRY_DBG; // [RULE14]
        next_r.cr4 = ENTRY_ZERO;
        next_r.extended_feature_enable = ENTRY_ZERO;
        next_r.cr0[CR0_PE] = 1'b0; // [RULE11]
        next_r.cr0[CR0_EM] = 1'b0;
        next_r.cr0[CR0_TS] = 1'b0;
        next_r.cr0[CR0_PG] = 1'b0;
        next_r.nmi_unmask = 1'b0; // [RULE16]
        next_r.sys_mgmt_mode = 1'b1; // [RULE23]
        next_r.mgmt_tag = 1'b1; // [RULE20]
        next_r.fetch_stop = 1'b0;
        next_r.state = ST_MGMT;
      end
      ST_MGMT: begin
        if (wr_ctrl && HWDATA[CTRL_INTERRUPT_RETURN_INSTR]) begin
          next_r.nmi_unmask = 1'b1; // [RULE16]
        end
        if (r.nmi_unmask && (r.nmi_pend || nmi_rise)) begin
          next_r.nmi_pend = 1'b0;
          next_r.nmi_take = 1'b1; // [RULE16]
        end
        if (wr_ctrl && HWDATA[CTRL_RESUME]) begin
          next_r.state = ST_RESUME;
        end
      end
      ST_RESUME: begin
        next_r.cr0 = r.sv_cr0; // [RULE22]
        next_r.flags = r.sv_flags;
        next_r.ip = r.sv_ip;
        next_r.dbg = r.sv_dbg;
        next_r.cs.base = seg_base(r.cs.sel);
        next_r.sys_mgmt_mode = 1'b0; // [RULE23]
        next_r.mgmt_tag = 1'b0; // [RULE20]
        next_r.nmi_unmask = 1'b0;
        next_r.state = ST_RUN;
      end
      default: next_r.state = ST_RUN;
    endcase
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      r <= '0;
      r.state <= ST_RUN;
      r.save_base <= RST_SAVE_BASE;
      r.cr0 <= RST_CR0;
      r.flags <= ENTRY_FLAGS;
      r.dbg <= ENTRY_DBG;
    end else begin
      r <= next_r;
    end
  end

  assign HRDATA = r.hrdata;
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;
  assign FETCH_STOP = r.fetch_stop;
  assign MGMT_ACK = r.ack;
  assign SYS_MGMT_MODE = r.sys_mgmt_mode;
  assign NMI_TAKE = r.nmi_take;
  assign MGMT_CACHE_TAG = r.mgmt_tag;
  // hardware interrupts need the enable flag and no entry in progress
  assign INTR_TAKE = intr_q && r.flags[FL_IF] && (r.state == ST_RUN || r.state == ST_MGMT)
                     && !r.mgmt_pend; // [RULE12] [RULE1]
  assign INIT_TAKE = init_q && !r.sys_mgmt_mode && (r.state == ST_RUN); // [RULE17]
  assign ADDR16_DEFAULT = r.sys_mgmt_mode; // [RULE7]
  assign SEG_LIMIT_OUT = r.sys_mgmt_mode ? SEG_LIMIT : 32'h0000_FFFF; // [RULE6]
  assign PUSH_IP = r.ip[15:0]; // [RULE18]
  assign IP_OUT = r.ip;
  assign FLAGS_OUT = r.flags;

  // exceptions and software interrupts are never blocked here [RULE12]
  logic unused_in;
  assign unused_in = SW_INT ^ EXC_REQ ^ ^HSIZE ^ HTRANS[0] ^ ^HADDR[31:5] ^ ^HADDR[1:0];

  sequence s_entry_go;
    r.state == ST_RUN && r.mgmt_pend;
  endsequence
  sequence s_drained;
    r.state == ST_DRAIN && PIPE_EMPTY && WBUF_EMPTY;
  endsequence

  AST_ACK_AFTER_DRAIN: assert property (@(posedge CLK_SYS) disable iff (RST) // [RULE5]
    s_drained |=> ##0 (r.state == ST_ACK) ##1 MGMT_ACK)
    else $error("ack not two cycles after drain");
  AST_NO_ACK_EARLY: assert property (@(posedge CLK_SYS) disable iff (RST) // [RULE4]
    (r.state == ST_DRAIN && !WBUF_EMPTY) |=> !MGMT_ACK ##1 !MGMT_ACK)
    else $error("ack before write buffer drained");
  AST_FETCH_STOP: assert property (@(posedge CLK_SYS) disable iff (RST) // [RULE3]
    s_entry_go |=> FETCH_STOP)
    else $error("fetch not stopped");
  AST_MGMT_PRIO: assert property (@(posedge CLK_SYS) disable iff (RST) // [RULE1]
    s_entry_go |=> !NMI_TAKE)
    else $error("nmi taken over management request");
  AST_ENTRY_VALUES: assert property (@(posedge CLK_SYS) disable iff (RST) // [RULE10]
    (r.state == ST_LOAD) |=> (IP_OUT == ENTRY_IP && FLAGS_OUT == ENTRY_FLAGS
      && r.dbg == ENTRY_DBG && r.cr4 == ENTRY_ZERO && r.extended_feature_enable == ENTRY_ZERO
      && SYS_MGMT_MODE))
    else $error("entry register values wrong");
  AST_CR0_CLEAR: assert property (@(posedge CLK_SYS) disable iff (RST) // [RULE11]
    (r.state == ST_LOAD) |=> (r.cr0[CR0_PE] == 1'b0 && r.cr0[CR0_PG] == 1'b0
      && r.cr0[CR0_EM] == 1'b0 && r.cr0[CR0_TS] == 1'b0
      && r.cr0[30:4] == $past(r.cr0[30:4])))
    else $error("cr0 entry update wrong");
  AST_CS_LOAD: assert property (@(posedge CLK_SYS) disable iff (RST) // [RULE8]
    (r.state == ST_LOAD) |=> (r.cs.base == $past(r.save_base)
      && r.cs.sel == $past(r.save_base[19:4]) && SEG_LIMIT_OUT == SEG_LIMIT))
    else $error("code segment load wrong");
  AST_DS_LOAD: assert property (@(posedge CLK_SYS) disable iff (RST) // [RULE9] [RULE19]
    (r.state == ST_LOAD) |=> (r.ds.sel == 16'h0000 && r.ds.base == 32'h0000_0000
      && r.ds.limit == 32'hFFFF_FFFF && r.ds.attr == 3'h3))
    else $error("data segment load wrong");
  AST_HW_INT_OFF: assert property (@(posedge CLK_SYS) disable iff (RST) // [RULE12] [RULE13]
    (r.state == ST_LOAD) |=> (!INTR_TAKE && !FLAGS_OUT[FL_IF] && !FLAGS_OUT[FL_TF]))
    else $error("hardware interrupts not masked on entry");
  AST_INIT_BLOCK: assert property (@(posedge CLK_SYS) disable iff (RST) // [RULE17]
    SYS_MGMT_MODE |-> !INIT_TAKE)
    else $error("init taken in management mode");
  AST_NMI_HELD: assert property (@(posedge CLK_SYS) disable iff (RST) // [RULE15]
    (SYS_MGMT_MODE && !r.nmi_unmask) |-> !NMI_TAKE)
    else $error("nmi taken while masked in mode");
  AST_MODE_CLEAR: assert property (@(posedge CLK_SYS) disable iff (RST) // [RULE22]
    (r.state == ST_RESUME) |=> (!SYS_MGMT_MODE && IP_OUT == $past(r.sv_ip)))
    else $error("resume did not restore state");
endmodule // smme_entry
`default_nettype wire

// ---- logic/smme_pkg.sv ----
// smme_pkg: constants and carriers for management-mode entry logic
// assumes a 200 MHz core clock and one AHB-Lite register slave
`default_nettype none
package smme_pkg;
  // register byte addresses
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_SAVE_BASE = 8'h08;
  localparam logic [7:0] OFS_CR0 = 8'h0C;
  localparam logic [7:0] OFS_FLAGS = 8'h10;
  localparam logic [7:0] OFS_IP = 8'h14;
  localparam logic [7:0] OFS_DBG = 8'h18;
  localparam logic [7:0] OFS_CS_SEL = 8'h1C;
  // control register field positions
  localparam int CTRL_RESUME = 0;
  localparam int CTRL_INTERRUPT_RETURN_INSTR = 1;
  // control-register-zero bit positions
  localparam int CR0_PE = 0;
  localparam int CR0_EM = 2;
  localparam int CR0_TS = 3;
  localparam int CR0_PG = 31;
  // flags bit positions
  localparam int FL_TF = 8;
  localparam int FL_IF = 9;
  // entry and reset values
  localparam logic [63:0] ENTRY_IP = 64'h0000_0000_0000_8000;
  localparam logic [63:0] ENTRY_FLAGS = 64'h0000_0000_0000_0002;
  localparam logic [63:0] ENTRY_DBG = 64'h0000_0000_0000_0400;
  localparam logic [63:0] ENTRY_ZERO = 64'h0000_0000_0000_0000;
  localparam logic [31:0] SEG_LIMIT = 32'hFFFF_FFFF;
  localparam logic [15:0] DATA_SEL = 16'h0000;
  localparam logic [31:0] RST_SAVE_BASE = 32'h0003_0000;
  localparam logic [31:0] RST_CR0 = 32'h0000_0010;
  localparam int SEL_SHIFT = 4;
  localparam logic [2:0] ATTR_RWX = 3'h7;
  localparam logic [2:0] ATTR_RW = 3'h3;

  typedef enum logic [2:0] {
    ST_RUN = 3'b000,
    ST_DRAIN = 3'b001,
    ST_ACK = 3'b010,
    ST_LOAD = 3'b011,
    ST_MGMT = 3'b100,
    ST_RESUME = 3'b101
  } smme_state_e;

  typedef struct packed {
    logic [15:0] sel;
    logic [31:0] base;
    logic [31:0] limit;
    logic [2:0] attr;
  } smme_seg_s;

  typedef struct packed {
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic hsel;
    logic [31:0] hwdata;
  } smme_ahb_req_s;

  typedef struct packed {
    smme_state_e state;
    logic sys_mgmt_mode;
    logic mgmt_pend;
    logic nmi_pend;
    logic nmi_unmask;
    logic ack;
    logic fetch_stop;
    logic nmi_take;
    logic mgmt_tag;
    logic [31:0] save_base;
    logic [31:0] cr0;
    logic [63:0] flags;
    logic [63:0] ip;
    logic [63:0] dbg;
    logic [63:0] cr4;
    logic [63:0] extended_feature_enable;
    logic [31:0] sv_cr0;
    logic [63:0] sv_flags;
    logic [63:0] sv_ip;
    logic [63:0] sv_dbg;
    smme_seg_s cs;
    smme_seg_s ds;
    logic [2:0] rd_addr;
    logic rd_wr;
    logic rd_act;
    logic [31:0] hrdata;
  } smme_st_s;

  function automatic logic [31:0] seg_base(input logic [15:0] sel);
    seg_base = {12'h000, sel, 4'h0};
  endfunction
endpackage : smme_pkg
`default_nettype wire

// ---- verif/smme_chipset.sv ----
// smme_chipset: system-logic model that raises management interrupts
// assumes the core clock domain; the bench asks for a request with raise
`default_nettype none
module smme_chipset
  import smme_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic raise,
  input wire logic mgmt_ack,
  output logic mgmt_int,
  output logic [7:0] ack_count
);
  always_ff @(posedge clk) begin
    if (rst) begin
      mgmt_int <= 1'b0;
      ack_count <= 8'h00;
    end else if (mgmt_ack) begin
      // request is withdrawn only once the core has acknowledged it
      mgmt_int <= 1'b0;
      ack_count <= ack_count + 8'h01;
    end else if (raise) begin
      mgmt_int <= 1'b1;
    end
  end
endmodule // smme_chipset
`default_nettype wire

// ---- verif/smme_entry_bench.sv ----
// smme_entry_bench: self-checking bench for the management-mode entry block
// assumes smme_pkg and smme_entry compiled first; chipset model in smme_chipset
`default_nettype none
module smme_entry_bench;
  import smme_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {logic [7:0] a; logic [31:0] e;} smme_row_s;
  smme_row_s rows [6] = '{'{OFS_STATUS, 32'h0000_0000}, '{OFS_SAVE_BASE, RST_SAVE_BASE},
    '{OFS_CR0, RST_CR0}, '{OFS_FLAGS, 32'h0000_0002}, '{OFS_IP, 32'h0000_0000},
    '{8'h40, 32'h0000_0000}};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic raise = 1'b0;
  logic nmi = 1'b0;
  logic intr = 1'b0;
  logic init = 1'b0;
  logic pipe = 1'b1;
  logic wbuf = 1'b1;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] rd;
  logic [31:0] hrdata;
  logic hreadyout, hresp, fetch_stop, mgmt_ack, mode, nmi_take, intr_take, init_take;
  logic cache_tag, addr16, mgmt_int;
  logic [31:0] seg_limit;
  logic [15:0] push_ip;
  logic [63:0] ip_out, flags_out;
  logic [7:0] acks;
  int nmi_cnt = 0;
  int bad_count = 0;
  int cmp_count = 0;

  smme_entry DUT (.CLK_SYS(clk), .RST(rst), .MGMT_INTERRUPT(mgmt_int), .NMI_REQ(nmi),
    .INTR_REQ(intr), .INIT_REQ(init), .PIPE_EMPTY(pipe), .WBUF_EMPTY(wbuf),
    .SW_INT(1'b0), .EXC_REQ(1'b0), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
    .HSIZE(3'b010), .HSEL(hsel), .HREADY(hreadyout), .HWDATA(hwdata), .HRDATA(hrdata),
    .HREADYOUT(hreadyout), .HRESP(hresp), .FETCH_STOP(fetch_stop), .MGMT_ACK(mgmt_ack),
    .SYS_MGMT_MODE(mode), .NMI_TAKE(nmi_take), .INTR_TAKE(intr_take),
    .INIT_TAKE(init_take), .MGMT_CACHE_TAG(cache_tag), .ADDR16_DEFAULT(addr16),
    .SEG_LIMIT_OUT(seg_limit), .PUSH_IP(push_ip), .IP_OUT(ip_out), .FLAGS_OUT(flags_out));
  smme_chipset chipset (.clk(clk), .rst(rst), .raise(raise), .mgmt_ack(mgmt_ack),
    .mgmt_int(mgmt_int), .ack_count(acks));

  initial begin
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (nmi_take === 1'b1) begin
      nmi_cnt <= nmi_cnt + 1;
    end
  end

  task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    haddr <= {24'h00_0000, a};
    htrans <= 2'b10;
    hwrite <= wr;
    hsel <= 1'b1;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    rd = hrdata;
  endtask
  task automatic pulse_mgmt();
    @(posedge clk);
    raise <= 1'b1;
    @(posedge clk);
    raise <= 1'b0;
  endtask
  task automatic pulse_nmi();
    @(posedge clk);
    nmi <= 1'b1;
    repeat (4) @(posedge clk);
    nmi <= 1'b0;
    repeat (6) @(posedge clk);
  endtask
  task automatic wait_ack(input logic [7:0] n);
    int k;
    k = 0;
    while (acks !== n && k < 60) begin
      @(posedge clk);
      k++;
    end
    chk("ack count", 64'(acks), 64'(n));
    repeat (3) @(posedge clk);
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    end_sim();
  end

  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    foreach (rows[i]) begin
      ahb(1'b0, rows[i].a, 32'h0000_0000);
      chk("reset read", 64'(rd), 64'(rows[i].e));
    end
    ahb(1'b1, OFS_CR0, 32'h8000_001D);
    ahb(1'b1, OFS_FLAGS, 32'h0000_0302);
    ahb(1'b1, OFS_DBG, 32'h0000_00FF);
    ahb(1'b1, OFS_SAVE_BASE, 32'h0004_0000);
    intr <= 1'b1;
    init <= 1'b1;
    pipe <= 1'b0;
    wbuf <= 1'b0;
    repeat (5) @(posedge clk);
    chk("init before entry", 64'(init_take), 64'h1);
    pulse_mgmt();
    repeat (8) @(posedge clk);
    chk("fetch stop", 64'(fetch_stop), 64'h1);
    chk("intr while pending", 64'(intr_take), 64'h0);
    pipe <= 1'b1;
    repeat (6) @(posedge clk);
    chk("ack before drain", 64'(acks), 64'h0);
    wbuf <= 1'b1;
    wait_ack(8'h01);
    chk("mode flag", 64'(mode), 64'h1);
    chk("entry ip", ip_out, ENTRY_IP);
    chk("entry flags", flags_out, ENTRY_FLAGS);
    chk("seg limit", 64'(seg_limit), 64'(SEG_LIMIT));
    chk("addr16", 64'(addr16), 64'h1);
    chk("cache tag", 64'(cache_tag), 64'h1);
    chk("fetch resumed", 64'(fetch_stop), 64'h0);
    chk("push ip", 64'(push_ip), 64'h8000);
    chk("intr in mode", 64'(intr_take), 64'h0);
    chk("init in mode", 64'(init_take), 64'h0);
    ahb(1'b0, OFS_CR0, 32'h0000_0000);
    chk("cr0 entry", 64'(rd), 64'h0000_0010);
    ahb(1'b0, OFS_DBG, 32'h0000_0000);
    chk("dbg entry", 64'(rd), 64'(ENTRY_DBG));
    ahb(1'b0, OFS_CS_SEL, 32'h0000_0000);
    chk("cs selector", 64'(rd), 64'h0000_4000);
    pulse_nmi();
    pulse_mgmt();
    repeat (6) @(posedge clk);
    ahb(1'b0, OFS_STATUS, 32'h0000_0000);
    chk("status latched", 64'(rd), 64'h0000_000E);
    chk("no reentry", 64'(acks), 64'h01);
    chk("nmi held", 64'(nmi_cnt), 64'h0);
    // both latched: the management request must win over the nmi
    ahb(1'b1, OFS_CTRL, 32'h0000_0001);
    wait_ack(8'h02);
    chk("nmi after mgmt", 64'(nmi_cnt), 64'h0);
    ahb(1'b1, OFS_CTRL, 32'h0000_0002);
    repeat (4) @(posedge clk);
    chk("nmi unmasked", 64'(nmi_cnt), 64'h1);
    ahb(1'b1, OFS_FLAGS, 32'h0000_0202);
    ahb(1'b1, OFS_IP, 32'h0001_2345);
    repeat (2) @(posedge clk);
    chk("intr re-enabled", 64'(intr_take), 64'h1);
    chk("push ip low", 64'(push_ip), 64'h2345);
    pulse_nmi();
    chk("later nmi", 64'(nmi_cnt), 64'h2);
    ahb(1'b1, OFS_CTRL, 32'h0000_0001);
    repeat (4) @(posedge clk);
    chk("mode left", 64'(mode), 64'h0);
    chk("ip back", ip_out, 64'h0);
    chk("flags back", flags_out, 64'h0000_0000_0000_0302);
    chk("seg limit out", 64'(seg_limit), 64'h0000_FFFF);
    chk("init after exit", 64'(init_take), 64'h1);
    ahb(1'b0, OFS_CR0, 32'h0000_0000);
    chk("cr0 back", 64'(rd), 64'h8000_001D);
    end_sim();
  end
endmodule // smme_entry_bench
`default_nettype wire
